/* File: src/edv_dispatch_top.sv */
// exception and interrupt vector dispatcher with AHB-Lite register window
// assumes a core that executes pushes one per cycle and an external controller on the request pins
`timescale 1ns/1ps
`include "edv_defs.svh"

module edv_dispatch_top #(
	parameter int TBL_DEPTH = 256
) (
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        INSN_BOUNDARY,
	input  wire logic [21:0] EXC_REQ,
	input  wire logic [31:0] EXC_ERRCODE,
	output logic             EXC_ACK,
	input  wire logic        NMI_REQ,
	output logic             NMI_ACK,
	input  wire logic        MASKABLE_REQUEST_PIN,
	input  wire logic [7:0]  MASK_VEC,
	output logic             MASK_ACK,
	input  wire logic        SWI_REQ,
	input  wire logic [7:0]  SWI_VEC,
	output logic             SWI_ACK,
	input  wire logic        SYSTEM_MGMT_REQUEST,
	output logic             SYSMGMT_ACK,
	input  wire logic        INTERRUPT_RETURN_INSTR,
	input  wire logic [15:0] RET_CS,
	input  wire logic [31:0] RET_IP,
	input  wire logic [31:0] RET_FLAGS,
	output logic             RET_ACK,
	input  wire logic [15:0] CUR_CS,
	input  wire logic [31:0] CUR_IP,
	output logic             CORE_HALT,
	output logic             PUSH_VALID,
	output logic      [31:0] PUSH_DATA,
	output logic      [15:0] TARGET_CS,
	output logic      [31:0] TARGET_IP,
	output logic             DISPATCH,
	output logic             TASK_CALL,
	output logic             RESUME,
	output logic      [7:0]  VECTOR,
	output edv_pkg::edv_class_t EVT_CLASS,
	output logic             SHUTDOWN,
	output logic      [31:0] PROCESSOR_FLAGS_WORD
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	edv_tbl_if tbl ();

	edv_pkg::edv_state_t state_reg;
	edv_pkg::edv_entry_t entry_reg;
	edv_pkg::edv_class_t new_cls;
	edv_pkg::edv_class_t cur_cls;
	logic [31:0] flags_reg;
	logic [7:0]  vec_reg;
	logic [31:0] err_reg;
	logic        has_err_reg;
	logic [15:0] save_cs_reg;
	logic [31:0] save_ip_reg;
	logic [7:0]  tbl_idx_reg;
	logic [31:0] off_stage_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [21:0] exc_legal;
	logic        exc_hit;
	logic [7:0]  exc_vec;
	logic        idle;
	logic        delivering;
	logic        take_sm, take_exc, take_nmi, take_mask, take_swi, take_ret;
	logic        take_evt;
	logic [7:0]  new_vec;
	logic        new_has_err;
	logic        cur_defined;
	logic        deliver_fault;
	logic        ahb_go;
	logic        flags_wr;

	function automatic logic [7:0] first_cause(input logic [21:0] r);
		logic [7:0] v;
		v = 8'h00;
		for (int i = `EDV_NCAUSE - 1; i >= 0; i--) begin
			if (r[i]) begin
				v = 8'(i);
			end
		end
		return v;
	endfunction

	edv_table #(.DEPTH(TBL_DEPTH)) u_table (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.t     (tbl.store)
	);

	edv_classify u_cls_new (
		.vec     (new_vec),
		.cls     (new_cls),
		.has_err (new_has_err),
		.defined ()
	);

	edv_classify u_cls_cur (
		.vec     (vec_reg),
		.cls     (cur_cls),
		.has_err (),
		.defined (cur_defined)
	);

	// ----------------------------------------
	// event acceptance
	// ----------------------------------------
	// reserved and internally made vectors never pass in from the pipeline
	assign exc_legal = EXC_REQ & `EDV_EXT_MASK;
	assign exc_hit   = |exc_legal;
	assign exc_vec   = first_cause(exc_legal);
	assign idle      = (state_reg == edv_pkg::EDV_ST_IDLE);
	assign delivering = (state_reg == edv_pkg::EDV_ST_LOOKUP) || (state_reg == edv_pkg::EDV_ST_PUSH_FLAGS) ||
		(state_reg == edv_pkg::EDV_ST_PUSH_CS) || (state_reg == edv_pkg::EDV_ST_PUSH_IP) ||
		(state_reg == edv_pkg::EDV_ST_PUSH_ERR);

	// synchronous exceptions and system management requests arrive mid-instruction, the rest wait for a boundary
	always_comb begin
		take_sm   = 1'b0;
		take_exc  = 1'b0;
		take_nmi  = 1'b0;
		take_mask = 1'b0;
		take_swi  = 1'b0;
		take_ret  = 1'b0;
		if (idle) begin
			if (SYSTEM_MGMT_REQUEST) begin
				take_sm = 1'b1;
			end else if (exc_hit) begin
				take_exc = 1'b1;
			end else if (INSN_BOUNDARY) begin
				if (NMI_REQ) begin
					take_nmi = 1'b1;
				end else if (MASKABLE_REQUEST_PIN && flags_reg[`EDV_IE_BIT]) begin
					take_mask = 1'b1;
				end else if (SWI_REQ) begin
					take_swi = 1'b1;
				end else if (INTERRUPT_RETURN_INSTR) begin
					take_ret = 1'b1;
				end
			end
		end
	end

	always_comb begin
		new_vec = exc_vec;
		if (take_nmi) begin
			new_vec = `EDV_VEC_NMI;
		end else if (take_mask) begin
			new_vec = MASK_VEC;
		end else if (take_swi) begin
			new_vec = SWI_VEC;
		end
	end

	assign take_evt    = take_exc || take_nmi || take_mask || take_swi;
	assign deliver_fault = delivering && (exc_hit ||
		(state_reg == edv_pkg::EDV_ST_LOOKUP && tbl.rd_b.gate == edv_pkg::EDV_GATE_NONE));
	assign EXC_ACK     = take_exc || (delivering && exc_hit);
	assign NMI_ACK     = take_nmi;
	assign MASK_ACK    = take_mask;
	assign SWI_ACK     = take_swi;
	assign SYSMGMT_ACK = take_sm;
	assign RET_ACK     = take_ret;
	assign CORE_HALT   = !idle;

	// ----------------------------------------
	// delivery sequencer
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg   <= edv_pkg::EDV_ST_IDLE;
			vec_reg     <= 8'h00;
			err_reg     <= 32'h0;
			has_err_reg <= 1'b0;
			save_cs_reg <= 16'h0;
			save_ip_reg <= 32'h0;
			entry_reg   <= '0;
		end else begin
			case (state_reg)
				edv_pkg::EDV_ST_IDLE: begin
					if (take_evt) begin
						vec_reg     <= new_vec;
						has_err_reg <= take_exc && new_has_err;
						err_reg     <= EXC_ERRCODE;
						save_cs_reg <= CUR_CS;
						save_ip_reg <= CUR_IP;
						state_reg   <= edv_pkg::EDV_ST_LOOKUP;
					end
				end
				edv_pkg::EDV_ST_LOOKUP, edv_pkg::EDV_ST_PUSH_FLAGS, edv_pkg::EDV_ST_PUSH_CS,
				edv_pkg::EDV_ST_PUSH_IP, edv_pkg::EDV_ST_PUSH_ERR: begin
					if (deliver_fault) begin
						// a second failure while already in double fault cannot be recovered
						if (vec_reg == `EDV_VEC_DFAULT) begin
							state_reg <= edv_pkg::EDV_ST_SHUTDOWN;
						end else begin
							vec_reg     <= `EDV_VEC_DFAULT;
							has_err_reg <= 1'b1;
							err_reg     <= 32'h0;
							state_reg   <= edv_pkg::EDV_ST_LOOKUP;
						end
					end else begin
						case (state_reg)
							edv_pkg::EDV_ST_LOOKUP: begin
								entry_reg <= tbl.rd_b;
								state_reg <= (tbl.rd_b.gate == edv_pkg::EDV_GATE_TASK) ?
									edv_pkg::EDV_ST_IDLE : edv_pkg::EDV_ST_PUSH_FLAGS;
							end
							edv_pkg::EDV_ST_PUSH_FLAGS: state_reg <= edv_pkg::EDV_ST_PUSH_CS;
							edv_pkg::EDV_ST_PUSH_CS:    state_reg <= edv_pkg::EDV_ST_PUSH_IP;
							edv_pkg::EDV_ST_PUSH_IP: begin
								state_reg <= has_err_reg ? edv_pkg::EDV_ST_PUSH_ERR : edv_pkg::EDV_ST_LOAD;
							end
							default: state_reg <= edv_pkg::EDV_ST_LOAD;
						endcase
					end
				end
				edv_pkg::EDV_ST_LOAD: state_reg <= edv_pkg::EDV_ST_IDLE;
				default: state_reg <= edv_pkg::EDV_ST_SHUTDOWN;
			endcase
		end
	end

	// ----------------------------------------
	// core-facing outputs
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			PUSH_VALID <= 1'b0;
			PUSH_DATA  <= 32'h0;
			TARGET_CS  <= 16'h0;
			TARGET_IP  <= 32'h0;
			DISPATCH   <= 1'b0;
			TASK_CALL  <= 1'b0;
			RESUME     <= 1'b0;
		end else begin
			PUSH_VALID <= 1'b0;
			DISPATCH   <= 1'b0;
			TASK_CALL  <= 1'b0;
			RESUME     <= 1'b0;
			if (take_ret) begin
				TARGET_CS <= RET_CS;
				TARGET_IP <= RET_IP;
				RESUME    <= 1'b1;
			end else if (!deliver_fault) begin
				case (state_reg)
					edv_pkg::EDV_ST_LOOKUP: begin
						if (tbl.rd_b.gate == edv_pkg::EDV_GATE_TASK) begin
							TARGET_CS <= tbl.rd_b.sel;
							TASK_CALL <= 1'b1;
						end
					end
					edv_pkg::EDV_ST_PUSH_FLAGS: begin
						PUSH_VALID <= 1'b1;
						PUSH_DATA  <= flags_reg;
					end
					edv_pkg::EDV_ST_PUSH_CS: begin
						PUSH_VALID <= 1'b1;
						PUSH_DATA  <= {16'h0, save_cs_reg};
					end
					edv_pkg::EDV_ST_PUSH_IP: begin
						PUSH_VALID <= 1'b1;
						PUSH_DATA  <= save_ip_reg;
					end
					edv_pkg::EDV_ST_PUSH_ERR: begin
						PUSH_VALID <= 1'b1;
						PUSH_DATA  <= err_reg;
					end
					edv_pkg::EDV_ST_LOAD: begin
						TARGET_CS <= entry_reg.sel;
						TARGET_IP <= entry_reg.off;
						DISPATCH  <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	assign VECTOR    = vec_reg;
	assign EVT_CLASS = cur_cls;
	assign SHUTDOWN  = (state_reg == edv_pkg::EDV_ST_SHUTDOWN);

	// ----------------------------------------
	// flags word
	// ----------------------------------------
	assign flags_wr = wr_pend_reg && wr_addr_reg == `EDV_OFF_FLAGS;

	// hardware updates win over a software write in the same cycle
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			flags_reg <= `EDV_FLAGS_RST;
		end else if (take_ret) begin
			flags_reg <= RET_FLAGS;
		end else if (state_reg == edv_pkg::EDV_ST_LOAD && entry_reg.gate == edv_pkg::EDV_GATE_IRQ) begin
			flags_reg[`EDV_IE_BIT] <= 1'b0;
		end else if (flags_wr) begin
			flags_reg <= HWDATA;
		end
	end

	assign PROCESSOR_FLAGS_WORD = flags_reg;

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	// zero wait states; only word accesses are meaningful, narrower ones act as words
	assign ahb_go    = HSEL && HREADY && HTRANS[1];
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign HRDATA    = rdata_reg;

	assign tbl.rd_idx_a = tbl_idx_reg;
	assign tbl.rd_idx_b = vec_reg;
	assign tbl.wr_en    = wr_pend_reg && wr_addr_reg == `EDV_OFF_TBL_SEL;
	assign tbl.wr_idx   = tbl_idx_reg;
	assign tbl.wr_entry = '{gate: edv_pkg::edv_gate_t'(HWDATA[17:16]), sel: HWDATA[15:0], off: off_stage_reg};

	always_comb begin
		rdata_next = 32'h0;
		if (HADDR[7:0] == `EDV_OFF_FLAGS) begin
			rdata_next = flags_reg;
		end else if (HADDR[7:0] == `EDV_OFF_STATUS) begin
			rdata_next = {14'h0, SHUTDOWN, !idle, 6'h0, cur_cls, vec_reg};
		end else if (HADDR[7:0] == `EDV_OFF_TBL_IDX) begin
			rdata_next = {24'h0, tbl_idx_reg};
		end else if (HADDR[7:0] == `EDV_OFF_TBL_OFF) begin
			rdata_next = tbl.rd_a.off;
		end else if (HADDR[7:0] == `EDV_OFF_TBL_SEL) begin
			rdata_next = {14'h0, tbl.rd_a.gate, tbl.rd_a.sel};
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rdata_reg   <= 32'h0;
		end else begin
			wr_pend_reg <= ahb_go && HWRITE;
			if (ahb_go) begin
				wr_addr_reg <= HADDR[7:0];
			end
			if (ahb_go && !HWRITE) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			tbl_idx_reg   <= 8'h00;
			off_stage_reg <= 32'h0;
		end else if (wr_pend_reg) begin
			if (wr_addr_reg == `EDV_OFF_TBL_IDX) begin
				tbl_idx_reg <= HWDATA[7:0];
			end else if (wr_addr_reg == `EDV_OFF_TBL_OFF) begin
				off_stage_reg <= HWDATA;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_mask_gate: assert property (MASK_ACK |-> flags_reg[`EDV_IE_BIT] && INSN_BOUNDARY)
		else $error("maskable request taken with interrupts disabled");
	chk_nmi_vector: assert property (NMI_ACK |=> vec_reg == `EDV_VEC_NMI && state_reg == edv_pkg::EDV_ST_LOOKUP)
		else $error("non-maskable request not on vector 2");
	chk_irq_gate_clear: assert property ((state_reg == edv_pkg::EDV_ST_LOAD && entry_reg.gate == edv_pkg::EDV_GATE_IRQ)
		|=> DISPATCH && !flags_reg[`EDV_IE_BIT])
		else $error("interrupt gate left interrupts enabled");
	chk_trap_gate_keep: assert property ((state_reg == edv_pkg::EDV_ST_LOAD && entry_reg.gate == edv_pkg::EDV_GATE_TRAP
		&& !flags_wr) |=> flags_reg[`EDV_IE_BIT] == $past(flags_reg[`EDV_IE_BIT]))
		else $error("trap gate changed the enable flag");
	chk_no_reserved: assert property (DISPATCH |-> cur_defined)
		else $error("dispatch on a reserved vector");
	chk_push_order: assert property ((state_reg == edv_pkg::EDV_ST_PUSH_FLAGS && !exc_hit)
		|=> PUSH_VALID && PUSH_DATA == $past(flags_reg) ##1 PUSH_VALID && PUSH_DATA[15:0] == save_cs_reg)
		else $error("push order broken");
	chk_double_fault: assert property ((deliver_fault && vec_reg != `EDV_VEC_DFAULT)
		|=> vec_reg == `EDV_VEC_DFAULT && state_reg == edv_pkg::EDV_ST_LOOKUP)
		else $error("fault during delivery did not raise vector 8");
	chk_return_restore: assert property (RET_ACK |=> RESUME && flags_reg == $past(RET_FLAGS)
		&& TARGET_IP == $past(RET_IP))
		else $error("return did not restore state");
	chk_task_call: assert property ((state_reg == edv_pkg::EDV_ST_LOOKUP && !exc_hit
		&& tbl.rd_b.gate == edv_pkg::EDV_GATE_TASK) |=> TASK_CALL && !PUSH_VALID)
		else $error("task gate not called as a task");
	chk_quotient_vec: assert property ((EXC_ACK && idle && EXC_REQ[0]) |=> vec_reg == `EDV_VEC_QUOT)
		else $error("quotient error not on vector 0");
endmodule

/* File: src/edv_defs.svh */
// constants of the exception vector dispatch unit
// assumes a 32-bit AHB-Lite register window decoded on the low address byte
`ifndef EDV_DEFS_SVH
`define EDV_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EDV_OFF_FLAGS    8'h00
`define EDV_OFF_STATUS   8'h04
`define EDV_OFF_TBL_IDX  8'h08
`define EDV_OFF_TBL_OFF  8'h0c
`define EDV_OFF_TBL_SEL  8'h10

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define EDV_FLAGS_RST    32'h0000_0002
`define EDV_IE_BIT       9
`define EDV_NCAUSE       22

// ----------------------------------------
// vectors
// ----------------------------------------
`define EDV_VEC_QUOT     8'h00
`define EDV_VEC_NMI      8'h02
`define EDV_VEC_DFAULT   8'h08
`define EDV_VEC_USER     8'h20

// cause masks indexed by vector 0..21
`define EDV_EXT_MASK     22'h3f7cfb
`define EDV_DEF_MASK     22'h3f7dff
`define EDV_ERR_MASK     22'h227d00
`define EDV_TRAP_MASK    22'h00001a
`define EDV_ABORT_MASK   22'h040100

`endif

/* File: src/edv_pkg.sv */
// types of the exception vector dispatch unit
// assumes nothing beyond a SystemVerilog compiler
package edv_pkg;

	typedef enum logic [1:0] {EDV_CLS_INTERRUPT, EDV_CLS_FAULT, EDV_CLS_TRAP, EDV_CLS_ABORT} edv_class_t;

	typedef enum logic [1:0] {EDV_GATE_NONE, EDV_GATE_IRQ, EDV_GATE_TRAP, EDV_GATE_TASK} edv_gate_t;

	typedef struct packed {
		edv_gate_t   gate;
		logic [15:0] sel;
		logic [31:0] off;
	} edv_entry_t;

	typedef enum logic [2:0] {
		EDV_ST_IDLE, EDV_ST_LOOKUP, EDV_ST_PUSH_FLAGS, EDV_ST_PUSH_CS,
		EDV_ST_PUSH_IP, EDV_ST_PUSH_ERR, EDV_ST_LOAD, EDV_ST_SHUTDOWN
	} edv_state_t;

endpackage

/* File: src/edv_tbl_if.sv */
// carrier between the dispatcher and its handler descriptor table
// assumes one writer and two readers in the same clock domain
`timescale 1ns/1ps
interface edv_tbl_if;
	logic                wr_en;
	logic [7:0]          wr_idx;
	edv_pkg::edv_entry_t wr_entry;
	logic [7:0]          rd_idx_a;
	edv_pkg::edv_entry_t rd_a;
	logic [7:0]          rd_idx_b;
	edv_pkg::edv_entry_t rd_b;

	modport store (input wr_en, wr_idx, wr_entry, rd_idx_a, rd_idx_b, output rd_a, rd_b);
	modport user  (output wr_en, wr_idx, wr_entry, rd_idx_a, rd_idx_b, input rd_a, rd_b);
endinterface

/* File: src/edv_table.sv */
// handler descriptor table held in flip-flops
// assumes one clock; reads are combinational, writes land at the edge
`timescale 1ns/1ps
module edv_table #(
	parameter int DEPTH = 256
) (
	input wire logic clk,
	input wire logic rst_n,
	edv_tbl_if.store t
);
	edv_pkg::edv_entry_t handler_descriptor_table [DEPTH];

	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				handler_descriptor_table[i] <= '0;
			end else if (t.wr_en && t.wr_idx == 8'(i)) begin
				handler_descriptor_table[i] <= t.wr_entry;
			end
		end
	end

	// entries past the depth read as absent gates
	assign t.rd_a = (int'(t.rd_idx_a) < DEPTH) ? handler_descriptor_table[t.rd_idx_a] : '0;
	assign t.rd_b = (int'(t.rd_idx_b) < DEPTH) ? handler_descriptor_table[t.rd_idx_b] : '0;
endmodule

/* File: src/edv_classify.sv */
// maps a vector to its class, error-code presence and defined status
// assumes vectors 32 and up come from software or the interrupt controller
`timescale 1ns/1ps
`include "edv_defs.svh"
module edv_classify (
	input  wire logic [7:0]       vec,
	output edv_pkg::edv_class_t   cls,
	output logic                  has_err,
	output logic                  defined
);
	logic fixed;

	always_comb begin
		fixed   = (vec < `EDV_VEC_USER);
		has_err = 1'b0;
		defined = !fixed;
		cls     = edv_pkg::EDV_CLS_INTERRUPT;
		if (vec < 8'(`EDV_NCAUSE)) begin
			has_err = 1'(`EDV_ERR_MASK >> vec[4:0]);
			defined = 1'(`EDV_DEF_MASK >> vec[4:0]);
			if (vec == `EDV_VEC_NMI) begin
				cls = edv_pkg::EDV_CLS_INTERRUPT;
			end else if (((`EDV_TRAP_MASK >> vec[4:0]) & 22'h1) != 22'h0) begin
				cls = edv_pkg::EDV_CLS_TRAP;
			end else if (((`EDV_ABORT_MASK >> vec[4:0]) & 22'h1) != 22'h0) begin
				cls = edv_pkg::EDV_CLS_ABORT;
			end else begin
				cls = edv_pkg::EDV_CLS_FAULT;
			end
		end
	end
endmodule

/* File: tb/edv_irq_ctrl.sv */
// model of the external interrupt controller facing the dispatcher's request pins
// assumes one clock shared with the dispatcher; the bench commands each raise
`timescale 1ns/1ps
module edv_irq_ctrl (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       raise_nmi,
	input  wire logic       raise_mask,
	input  wire logic [7:0] vec_in,
	input  wire logic       nmi_ack,
	input  wire logic       mask_ack,
	output logic            nmi_req,
	output logic            mask_req,
	output logic [7:0]      mask_vec
);
	// requests are levels held until the core acknowledges them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_req <= 1'h0;
			mask_req <= 1'h0;
			mask_vec <= 8'h0;
		end else begin
			if (raise_nmi) begin
				nmi_req <= 1'h1;
			end else if (nmi_ack) begin
				nmi_req <= 1'h0;
			end
			if (raise_mask) begin
				mask_req <= 1'h1;
				mask_vec <= vec_in;
			end else if (mask_ack || !mask_req) begin
				mask_req <= 1'h0;
				// released vector keeps changing, so a stale value never looks valid
				mask_vec <= ~mask_vec;
			end
		end
	end
endmodule

/* File: tb/tb_exception_vector_dispatch.sv */
// self-checking bench of the exception vector dispatcher
// assumes the dispatcher sources and the controller model are compiled first
`timescale 1ns/1ps
module tb_exception_vector_dispatch;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'h0, bnd = 1'h0, nmi_go = 1'h0, msk_go = 1'h0, mgmt = 1'h0, interrupt_return_instr = 1'h0, swi = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, errc = 32'h0, rip = 32'h0, rfl = 32'h0, cip = 32'h0;
	logic [21:0] exc = 22'h0;
	logic [15:0] rcs = 16'h0, ccs = 16'h0;
	logic [7:0]  mv = 8'h0;
	logic [31:0] hrdata, pdata, tip, pfw, rd;
	logic        hrdy, hresp, eack, nack, mack, sack, gack, rack, halt, pval, disp, tcall, resume, shut;
	logic        nreq, mreq;
	logic [15:0] tcs;
	logic [7:0]  vec, mvec;
	logic [15:0] esel [256];
	logic [31:0] eoff [256];
	logic [31:0] q [$];
	int          err_total = 0;
	int          checks = 0;
	int          kind;
	edv_pkg::edv_class_t cls;

	always #2.5 clk = ~clk;

	edv_dispatch_top #(.TBL_DEPTH(256)) dut (
		.CLOCK(clk), .RST_N(rst_n), .HSEL(1'h1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
		.INSN_BOUNDARY(bnd), .EXC_REQ(exc), .EXC_ERRCODE(errc), .EXC_ACK(eack), .NMI_REQ(nreq),
		.NMI_ACK(nack), .MASKABLE_REQUEST_PIN(mreq), .MASK_VEC(mvec), .MASK_ACK(mack), .SWI_REQ(swi),
		.SWI_VEC(mv), .SWI_ACK(sack), .SYSTEM_MGMT_REQUEST(mgmt), .SYSMGMT_ACK(gack),
		.INTERRUPT_RETURN_INSTR(interrupt_return_instr), .RET_CS(rcs), .RET_IP(rip), .RET_FLAGS(rfl), .RET_ACK(rack),
		.CUR_CS(ccs), .CUR_IP(cip), .CORE_HALT(halt), .PUSH_VALID(pval), .PUSH_DATA(pdata),
		.TARGET_CS(tcs), .TARGET_IP(tip), .DISPATCH(disp), .TASK_CALL(tcall), .RESUME(resume),
		.VECTOR(vec), .EVT_CLASS(cls), .SHUTDOWN(shut), .PROCESSOR_FLAGS_WORD(pfw));

	edv_irq_ctrl pic (.clk(clk), .rst_n(rst_n), .raise_nmi(nmi_go), .raise_mask(msk_go), .vec_in(mv),
		.nmi_ack(nack), .mask_ack(mack), .nmi_req(nreq), .mask_req(mreq), .mask_vec(mvec));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_sim();
		$display("errors %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wait_rdy();
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hrdy !== 1'h1 && n < 50);
		if (n >= 50)
			cmp(32'h0, 32'h1, "bus hang");
		if (n >= 50)
			end_sim();
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic set_entry(input logic [7:0] v, input logic [1:0] g);
		esel[v] = 16'($urandom());
		eoff[v] = $urandom();
		bus(1'h1, 8'h08, {24'h0, v});
		bus(1'h1, 8'h0c, eoff[v]);
		bus(1'h1, 8'h10, {14'h0, g, esel[v]});
	endtask

	// gathers pushed words until the handler is entered
	task automatic collect();
		kind = 0;
		q.delete();
		ccs <= 16'($urandom());
		cip <= $urandom();
		errc <= $urandom();
		for (int n = 0; n < 40 && kind == 0; n++) begin
			@(posedge clk);
			nmi_go <= 1'h0;
			msk_go <= 1'h0;
			// the take happens at this edge, so one-shot requests drop here
			exc <= 22'h0;
			swi <= 1'h0;
			#1;
			if (pval === 1'h1)
				q.push_back(pdata);
			if (disp === 1'h1)
				kind = 1;
			if (tcall === 1'h1)
				kind = 2;
		end
		if (kind == 0) begin
			cmp(32'h0, 32'h1, "dispatch hang");
			end_sim();
		end
		@(posedge clk);
	endtask

	task automatic chk_disp(input logic [7:0] v, input logic [31:0] f0, input logic [31:0] e, input int np);
		cmp(32'(kind), 32'h1, "gate kind");
		cmp(32'(q.size()), 32'(np), "push count");
		cmp(q[0], f0, "flags push");
		cmp({16'h0, q[1][15:0]}, {16'h0, ccs}, "cs push");
		cmp(q[2], cip, "ip push");
		if (np == 4)
			cmp(q[3], e, "err push");
		cmp({24'h0, vec}, {24'h0, v}, "vector");
		cmp({16'h0, tcs}, {16'h0, esel[v]}, "target cs");
		cmp(tip, eoff[v], "target ip");
	endtask

	task automatic do_ret(input logic [31:0] f);
		int n = 0;
		rcs <= 16'($urandom());
		rip <= $urandom();
		rfl <= f;
		interrupt_return_instr <= 1'h1;
		bnd <= 1'h1;
		#1;
		while (rack !== 1'h1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 20) begin
			cmp(32'h0, 32'h1, "return hang");
			end_sim();
		end
		@(posedge clk);
		interrupt_return_instr <= 1'h0;
		// boundary drops with the return so a pending request waits for the caller
		bnd <= 1'h0;
		#1;
		cmp({31'h0, resume}, 32'h1, "resume");
		cmp({tcs, 16'h0}, {rcs, 16'h0}, "ret cs");
		cmp(tip, rip, "ret ip");
		cmp(pfw, f, "ret flags");
		@(posedge clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		rd = $urandom(32'h6c51);
		repeat (8) @(posedge clk);
		rst_n <= 1'h1;
		cmp(pfw, 32'h2, "flags reset");
		bus(1'h0, 8'h00, 32'h0);
		cmp(rd, 32'h2, "flags read");
		bus(1'h0, 8'h40, 32'h0);
		cmp(rd, 32'h0, "unmapped");
		bus(1'h1, 8'h00, 32'h202);
		set_entry(8'h0d, 2'h1);
		set_entry(8'h03, 2'h2);
		set_entry(8'h08, 2'h1);
		set_entry(8'h02, 2'h2);
		set_entry(8'h06, 2'h3);
		set_entry(8'h00, 2'h2);
		mv = 8'h20 + 8'($urandom_range(223));
		set_entry(mv, 2'h1);
		bus(1'h0, 8'h0c, 32'h0);
		cmp(rd, eoff[mv], "entry readback");
		exc <= 22'h2000;
		collect();
		chk_disp(8'h0d, 32'h202, errc, 4);
		cmp({30'h0, cls}, 32'h1, "fault class");
		cmp(pfw, 32'h2, "ie cleared");
		do_ret(32'h202);
		exc <= 22'h8;
		collect();
		chk_disp(8'h03, 32'h202, 32'h0, 3);
		cmp(pfw, 32'h202, "ie kept");
		cmp({30'h0, cls}, 32'h2, "trap class");
		// maskable must wait for an instruction boundary
		msk_go <= 1'h1;
		@(posedge clk);
		msk_go <= 1'h0;
		repeat (10) @(posedge clk);
		cmp({30'h0, halt, mreq}, 32'h1, "no boundary");
		bnd <= 1'h1;
		collect();
		chk_disp(mv, 32'h202, 32'h0, 3);
		cmp(pfw, 32'h2, "ie cleared");
		msk_go <= 1'h1;
		@(posedge clk);
		msk_go <= 1'h0;
		repeat (10) @(posedge clk);
		cmp({30'h0, halt, mreq}, 32'h1, "masked");
		nmi_go <= 1'h1;
		collect();
		chk_disp(8'h02, 32'h2, 32'h0, 3);
		// restored enable flag lets the pending maskable request in
		do_ret(32'h202);
		bnd <= 1'h1;
		collect();
		chk_disp(mv, 32'h202, 32'h0, 3);
		exc <= 22'h80;
		collect();
		chk_disp(8'h08, 32'h2, 32'h0, 4);
		exc <= 22'h40;
		collect();
		cmp(32'(kind), 32'h2, "task call");
		cmp(32'(q.size()), 32'h0, "task pushes");
		cmp({16'h0, tcs}, {16'h0, esel[6]}, "task sel");
		cmp({24'h0, vec}, 32'h6, "opcode vector");
		exc <= 22'h1;
		#1;
		cmp({31'h0, eack}, 32'h1, "exc ack");
		collect();
		chk_disp(8'h00, 32'h2, 32'h0, 3);
		cmp({30'h0, cls}, 32'h1, "quotient class");
		swi <= 1'h1;
		#1;
		cmp({31'h0, sack}, 32'h1, "swi ack");
		collect();
		chk_disp(mv, 32'h2, 32'h0, 3);
		mgmt <= 1'h1;
		#1;
		cmp({31'h0, gack}, 32'h1, "mgmt ack");
		@(posedge clk);
		mgmt <= 1'h0;
		#1;
		cmp({30'h0, halt, shut}, 32'h0, "mgmt no dispatch");
		cmp(pfw, 32'h2, "mgmt flags");
		end_sim();
	end
endmodule
